// *** gpp_pkg.sv ***
// Package for the two-port pin block: widths, bus addresses, reset values.
// Assumes an 8-bit processor bus with byte addresses.
package gpp_pkg;
    localparam int          GPP_W          = 8;
    localparam int          GPP_AW         = 8;
    localparam logic [7:0]  GPP_ADDR_PP    = 8'h00;
    localparam logic [7:0]  GPP_ADDR_PP_D  = 8'h01;
    localparam logic [7:0]  GPP_ADDR_OD    = 8'h02;
    localparam logic [7:0]  GPP_ADDR_OD_D  = 8'h03;
    localparam logic [7:0]  GPP_DIR_RST    = 8'h00;
    localparam logic [7:0]  GPP_LAT_RST    = 8'h00;
    localparam logic [7:0]  GPP_ZERO       = 8'h00;
    localparam logic [1:0]  GPP_SEL_PP     = 2'h0;
    localparam logic [1:0]  GPP_SEL_PP_D   = 2'h1;
    localparam logic [1:0]  GPP_SEL_OD     = 2'h2;
    localparam logic [1:0]  GPP_SEL_OD_D   = 2'h3;
endpackage

// *** gpp_sync.sv ***
// Two-flop synchroniser for a bank of pin inputs.
// Assumes pins are asynchronous to clock.
`timescale 1ns/1ps
module gpp_sync
    import gpp_pkg::*;
(
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_b,
    // Pins in, synchronised out
    input  wire logic [GPP_W-1:0] pin_in,
    output logic      [GPP_W-1:0] pin_sync
);
    logic [GPP_W-1:0] meta_reg;
    logic [GPP_W-1:0] meta_next;
    logic [GPP_W-1:0] sync_reg;
    logic [GPP_W-1:0] sync_next;

    always_comb begin
        meta_next = pin_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= GPP_ZERO;
            sync_reg <= GPP_ZERO;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign pin_sync = sync_reg;
endmodule

// *** gpp_ports.sv ***
// What this block does
// - Each pin has its own direction bit
// - Direction zero is input, one is output
// - Output pins read back latch, not pin
// - Input pins stay undriven, buffer off
// - Writes to input pins only touch latch
// - Second port open-drain, first push-pull
//
// Holds the push-pull and open-drain port logic with its bus registers.
// Four registers: a latch and a direction register for each port.
// Assumes a simple synchronous processor bus, one strobe per access.
// Assumes pins are resolved outside from each out/oe pair.
`timescale 1ns/1ps
module gpp_ports
    import gpp_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_b,
    // Processor bus
    input  wire logic [GPP_AW-1:0] bus_addr,
    input  wire logic              bus_wr,
    input  wire logic              bus_rd,
    input  wire logic [GPP_W-1:0]  bus_wdata,
    output logic      [GPP_W-1:0]  bus_rdata,
    // Push-pull port pins
    input  wire logic [GPP_W-1:0]  push_pull_port_in,
    output logic      [GPP_W-1:0]  push_pull_port_out,
    output logic      [GPP_W-1:0]  push_pull_port_oe,
    // Open-drain port pins
    input  wire logic [GPP_W-1:0]  open_drain_port_in,
    output logic      [GPP_W-1:0]  open_drain_port_out,
    output logic      [GPP_W-1:0]  open_drain_port_oe
);
    logic [GPP_W-1:0] pp_lat_reg;
    logic [GPP_W-1:0] pp_lat_next;
    logic [GPP_W-1:0] pp_dir_reg;
    logic [GPP_W-1:0] pp_dir_next;
    logic [GPP_W-1:0] od_lat_reg;
    logic [GPP_W-1:0] od_lat_next;
    logic [GPP_W-1:0] od_dir_reg;
    logic [GPP_W-1:0] od_dir_next;
    logic [GPP_W-1:0] rdata_reg;
    logic [GPP_W-1:0] rdata_next;
    logic [GPP_W-1:0] pp_out_reg;
    logic [GPP_W-1:0] pp_out_next;
    logic [GPP_W-1:0] pp_oe_reg;
    logic [GPP_W-1:0] pp_oe_next;
    logic [GPP_W-1:0] od_out_reg;
    logic [GPP_W-1:0] od_out_next;
    logic [GPP_W-1:0] od_oe_reg;
    logic [GPP_W-1:0] od_oe_next;
    logic [GPP_W-1:0] pp_sync;
    logic [GPP_W-1:0] od_sync;
    logic [GPP_W-1:0] pp_view;
    logic [GPP_W-1:0] od_view;
    logic             addr_hit;
    logic [1:0]       addr_sel;
    logic             wr_hit;
    logic             rd_hit;

    gpp_sync u_pp_sync (
        .clock    (clock),
        .rst_b    (rst_b),
        .pin_in   (push_pull_port_in),
        .pin_sync (pp_sync)
    );

    gpp_sync u_od_sync (
        .clock    (clock),
        .rst_b    (rst_b),
        .pin_in   (open_drain_port_in),
        .pin_sync (od_sync)
    );

    // Per-pin read mux: latch for outputs, pin for inputs
    genvar gi;
    generate
        for (gi = 0; gi < GPP_W; gi++) begin : g_pin
            assign pp_view[gi] = pp_dir_reg[gi] ? pp_lat_reg[gi]
                                                : pp_sync[gi];
            assign od_view[gi] = od_dir_reg[gi] ? od_lat_reg[gi]
                                                : od_sync[gi];
        end
    endgenerate

    // Address decode onto one of four registers
    always_comb begin
        addr_hit = 1'h1;
        addr_sel = GPP_SEL_PP;
        case (bus_addr)
            GPP_ADDR_PP:   addr_sel = GPP_SEL_PP;
            GPP_ADDR_PP_D: addr_sel = GPP_SEL_PP_D;
            GPP_ADDR_OD:   addr_sel = GPP_SEL_OD;
            GPP_ADDR_OD_D: addr_sel = GPP_SEL_OD_D;
            default:       addr_hit = 1'h0;
        endcase
        wr_hit = bus_wr & addr_hit;
        rd_hit = bus_rd & addr_hit;
    end

    // Register writes; latch written whatever the direction
    always_comb begin
        pp_lat_next = pp_lat_reg;
        pp_dir_next = pp_dir_reg;
        od_lat_next = od_lat_reg;
        od_dir_next = od_dir_reg;
        if (wr_hit) begin
            case (addr_sel)
                GPP_SEL_PP:   pp_lat_next = bus_wdata;
                GPP_SEL_PP_D: pp_dir_next = bus_wdata;
                GPP_SEL_OD:   od_lat_next = bus_wdata;
                GPP_SEL_OD_D: od_dir_next = bus_wdata;
                default: ;
            endcase
        end
    end

    // Latch and direction registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pp_lat_reg <= GPP_LAT_RST;
            pp_dir_reg <= GPP_DIR_RST;
            od_lat_reg <= GPP_LAT_RST;
            od_dir_reg <= GPP_DIR_RST;
        end else begin
            pp_lat_reg <= pp_lat_next;
            pp_dir_reg <= pp_dir_next;
            od_lat_reg <= od_lat_next;
            od_dir_reg <= od_dir_next;
        end
    end

    // Read data; unmapped reads give zero, held until next read
    always_comb begin
        rdata_next = rdata_reg;
        if (bus_rd) begin
            rdata_next = GPP_ZERO;
        end
        if (rd_hit) begin
            case (addr_sel)
                GPP_SEL_PP:   rdata_next = pp_view;
                GPP_SEL_PP_D: rdata_next = pp_dir_reg;
                GPP_SEL_OD:   rdata_next = od_view;
                GPP_SEL_OD_D: rdata_next = od_dir_reg;
                default:      rdata_next = GPP_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= GPP_ZERO;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Pin drivers follow the next latch and direction values
    always_comb begin
        // Push-pull: drive latch while direction is one
        pp_out_next = pp_lat_next;
        pp_oe_next  = pp_dir_next;
        // Open-drain: pull low for zero, release for one
        od_out_next = GPP_ZERO;
        od_oe_next  = od_dir_next & ~od_lat_next;
    end

    // Pin driver registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pp_out_reg <= GPP_ZERO;
            pp_oe_reg  <= GPP_ZERO;
            od_out_reg <= GPP_ZERO;
            od_oe_reg  <= GPP_ZERO;
        end else begin
            pp_out_reg <= pp_out_next;
            pp_oe_reg  <= pp_oe_next;
            od_out_reg <= od_out_next;
            od_oe_reg  <= od_oe_next;
        end
    end

    assign bus_rdata           = rdata_reg;
    assign push_pull_port_out  = pp_out_reg;
    assign push_pull_port_oe   = pp_oe_reg;
    assign open_drain_port_out = od_out_reg;
    assign open_drain_port_oe  = od_oe_reg;
endmodule

// *** gpp_ports_sva.sv ***
// Checker for the port block, bound to its ports.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module gpp_ports_sva
    import gpp_pkg::*;
(
    input wire logic              clock, rst_b, bus_wr, bus_rd,
    input wire logic [GPP_AW-1:0] bus_addr,
    input wire logic [GPP_W-1:0]  bus_wdata, bus_rdata,
    input wire logic [GPP_W-1:0]  push_pull_port_out, push_pull_port_oe,
    input wire logic [GPP_W-1:0]  open_drain_port_out, open_drain_port_oe
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    wire w_ppl = bus_wr && bus_addr == GPP_ADDR_PP;
    wire w_ppd = bus_wr && bus_addr == GPP_ADDR_PP_D;
    wire w_odl = bus_wr && bus_addr == GPP_ADDR_OD;
    wire w_odd = bus_wr && bus_addr == GPP_ADDR_OD_D;
    wire r_pp  = bus_rd && !bus_wr && bus_addr == GPP_ADDR_PP;
    AST_RST: assert property ($rose(rst_b) |->
        (push_pull_port_oe | open_drain_port_oe) == GPP_ZERO) else $error("rst");
    AST_PPD: assert property (w_ppd |=>
        push_pull_port_oe == $past(bus_wdata)) else $error("pp dir");
    AST_PPL: assert property (w_ppl |=>
        push_pull_port_out == $past(bus_wdata)) else $error("pp latch");
    AST_ODO: assert property (
        open_drain_port_out == GPP_ZERO) else $error("od out");
    AST_ODL: assert property (w_odl |=>
        (open_drain_port_oe & $past(bus_wdata)) == GPP_ZERO) else $error("od");
    AST_ODD: assert property (w_odd && bus_wdata == GPP_ZERO |=>
        open_drain_port_oe == GPP_ZERO) else $error("od dir");
    AST_RDB: assert property (r_pp |=> ((bus_rdata ^
        push_pull_port_out) & push_pull_port_oe) == GPP_ZERO) else $error("rd");
    AST_DIR: assert property (!bus_wr |=>
        $stable(push_pull_port_oe)) else $error("dir moved");
    cover property (w_ppd);
    cover property (w_odl);
    cover property (r_pp);
endmodule
bind gpp_ports gpp_ports_sva i_gpp_ports_sva (.clock, .rst_b, .bus_wr,
    .bus_rd, .bus_addr, .bus_wdata, .bus_rdata, .push_pull_port_out,
    .push_pull_port_oe, .open_drain_port_out, .open_drain_port_oe);

// *** gpp_pins.sv ***
// Outside circuit: sources on the push-pull pins, pull-ups on open-drain.
// Assumes one out/oe pair per pin from the block.
`timescale 1ns/1ps
module gpp_pins
    import gpp_pkg::*;
(
    input  wire logic [GPP_W-1:0] pp_out, pp_oe, od_oe, pp_ext, od_ext,
    output logic      [GPP_W-1:0] pp_pin, od_pin
);
    assign pp_pin = (pp_oe & pp_out) | (~pp_oe & pp_ext);
    assign od_pin = ~od_oe & od_ext;
endmodule

// *** test_gpp_ports.sv ***
// Bench for the port block with the outside pin model.
// Assumes one strobe per access and read data one cycle after the strobe.
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin \
    failures++; $display("Error %s exp %h got %h", n, e, a); end end
module test_gpp_ports
    import gpp_pkg::*;
;
    logic              clock = 0, rst_b = 0, bus_wr = 0, bus_rd = 0;
    logic [GPP_AW-1:0] bus_addr = 8'h00;
    logic [GPP_W-1:0]  bus_wdata = 8'h00, rd, pp_ext = 8'h00, od_ext = 8'hFF;
    wire logic [GPP_W-1:0] bus_rdata, pp_out, pp_oe, od_out, od_oe;
    wire logic [GPP_W-1:0] pp_pin, od_pin;
    int                failures = 0, n_compared = 0;
    always #12.5 clock = ~clock;
    gpp_ports i_gpp_ports (.clock, .rst_b, .bus_addr, .bus_wr, .bus_rd,
        .bus_wdata, .bus_rdata, .push_pull_port_in(pp_pin),
        .push_pull_port_out(pp_out), .push_pull_port_oe(pp_oe),
        .open_drain_port_in(od_pin), .open_drain_port_out(od_out),
        .open_drain_port_oe(od_oe));
    gpp_pins i_gpp_pins (.pp_out, .pp_oe, .od_oe, .pp_ext, .od_ext,
        .pp_pin, .od_pin);
    task automatic wr(input logic [7:0] a, d);
        @(posedge clock) #2 {bus_wr, bus_addr, bus_wdata} = {1'b1, a, d};
        @(posedge clock) #2 bus_wr = 0;
    endtask
    task automatic rdb(input logic [7:0] a);
        repeat (3) @(posedge clock);
        #2 {bus_rd, bus_addr} = {1'b1, a};
        @(posedge clock) #2 bus_rd = 0;
        rd = bus_rdata;
    endtask
    task automatic t_pp;
        `CHK("pp_oe", 8'h00, pp_oe)
        pp_ext = 8'h0F;
        wr(GPP_ADDR_PP, 8'h3C);
        `CHK("pp_oe", 8'h00, pp_oe)
        wr(GPP_ADDR_PP_D, 8'hA5);
        `CHK("pp_oe", 8'hA5, pp_oe)
        `CHK("pp_out", 8'h3C, pp_out)
        rdb(GPP_ADDR_PP);
        `CHK("pp_rd", (8'h3C & 8'hA5) | (8'h0F & ~8'hA5), rd)
        rdb(GPP_ADDR_PP_D);
        `CHK("pp_dir", 8'hA5, rd)
    endtask
    task automatic t_od;
        `CHK("od_oe", 8'h00, od_oe)
        od_ext = 8'h33;
        wr(GPP_ADDR_OD_D, 8'hFF);
        wr(GPP_ADDR_OD, 8'h0F);
        `CHK("od_oe", 8'hF0, od_oe)
        `CHK("od_out", 8'h00, od_out)
        rdb(GPP_ADDR_OD);
        `CHK("od_rd", 8'h0F, rd)
        wr(GPP_ADDR_OD_D, 8'h00);
        `CHK("od_oe", 8'h00, od_oe)
        rdb(GPP_ADDR_OD);
        `CHK("od_in", 8'h33, rd)
        rdb(GPP_ADDR_OD_D);
        `CHK("od_dir", 8'h00, rd)
        rdb(8'h04);
        `CHK("unmapped", 8'h00, rd)
    endtask
    task automatic tally_and_finish;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock);
        #2 rst_b = 1;
        t_od();
        t_pp();
        tally_and_finish();
    end
    initial begin
        #10000;
        failures++;
        tally_and_finish();
    end
endmodule
